// File: hw/cantm_errcnt.sv
`timescale 1ns/1ps
module cantm_errcnt #(
    parameter int unsigned TW = 9,
    parameter int unsigned RW = 8
) (
    input  wire logic                 pclk,    // clock
    input  wire logic                 presetn, // async reset, low
    input  wire logic                 freeze,  // hold both counters
    input  wire cantm_pkg::cantm_err_s evt,    // protocol events
    output logic [TW-1:0]             tec,     // transmit errors
    output logic [RW-1:0]             rec      // receive errors
);

    logic [TW-1:0] tec_r, tec_nxt;
    logic [RW-1:0] rec_r, rec_nxt;

    // saturating step; +1 and a decrement in one cycle net out; +8 and a decrement give +7
    function automatic logic [15:0] step(input logic [15:0] v,
                                         input logic [15:0] max,
                                         input logic inc1,
                                         input logic inc8,
                                         input logic dec);
        logic [16:0] s;
        s = {1'b0, v};
        if (inc8) begin
            s = s + {13'h0, cantm_pkg::STEP_BIG};
        end else if (inc1) begin
            s = s + {13'h0, cantm_pkg::STEP_ONE};
        end
        if (dec && s != 17'h0) begin
            s = s - 17'h1;
        end
        if (s > {1'b0, max}) begin
            s = {1'b0, max};
        end
        return s[15:0];
    endfunction : step

    always_comb begin
        tec_nxt = tec_r;
        rec_nxt = rec_r;
        if (!freeze) begin
            tec_nxt = TW'(step(16'(tec_r), 16'(cantm_pkg::TEC_MAX),
                              evt.tec_inc1, evt.tec_inc8, evt.tec_dec));
            rec_nxt = RW'(step(16'(rec_r), 16'(cantm_pkg::REC_MAX),
                              evt.rec_inc1, evt.rec_inc8, evt.rec_dec));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tec_r <= '0;
            rec_r <= '0;
        end else begin
            tec_r <= tec_nxt;
            rec_r <= rec_nxt;
        end
    end

    assign tec = tec_r;
    assign rec = rec_r;

endmodule : cantm_errcnt

// File: hw/cantm_top.sv
// What this block does
// - auto-ack bit 12 set: node makes its own acknowledge; clear: it does not
// - freeze bit 11 set: both error counters hold their values
// - freeze bit clear: error counters count per protocol events
// - rx-disable bit 10 clear: core receive input comes from rx pin
// - rx-disable set, loop clear: core receive input stays recessive
// - rx-disable set, loop set: core receive input is internal tx value
// - test bits act only with master enable set; else normal mode
// - loop acts only with rx-disable set: loop clear gives recessive rx; loop set feeds rx from internal tx
`timescale 1ns/1ps
module cantm_top (
    input  wire logic                  pclk,         // apb clock
    input  wire logic                  presetn,      // async reset, low
    input  wire logic                  psel,         // apb select
    input  wire logic                  penable,      // apb access phase
    input  wire logic                  pwrite,       // apb write
    input  wire logic [7:0]            paddr,        // apb byte address
    input  wire logic [31:0]           pwdata,       // apb write data
    output logic [31:0]                prdata,       // apb read data
    output logic                       pready,       // apb ready
    output logic                       pslverr,      // apb error
    input  wire logic                  core_tx,      // tx bit from core
    input  wire logic                  core_ack_slot,// own frame ack slot
    input  wire cantm_pkg::cantm_err_s core_err,     // counter events
    input  wire logic                  can_rx_pin,   // bus receive pin
    output logic                       can_tx_pin,   // bus transmit pin
    output logic                       core_rx,      // rx bit to core
    output logic [8:0]                 tec,          // transmit err count
    output logic [7:0]                 rec           // receive err count
);

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    cantm_pkg::cantm_ctrl_s ctrl_r, ctrl_nxt;
    logic [31:0]            prdata_r, prdata_nxt;
    logic                   pready_r, pready_nxt;
    logic                   pslverr_r, pslverr_nxt;
    logic [8:0]             tec_w;
    logic [7:0]             rec_w;

    function automatic logic mapped(input logic [7:0] a);
        return a == cantm_pkg::ADDR_CTRL || a == cantm_pkg::ADDR_ERRCNT ||
               a == cantm_pkg::ADDR_STATUS;
    endfunction : mapped

    // effective controls: everything gated by the master enable
    function automatic cantm_pkg::cantm_ctrl_s gate(
        input cantm_pkg::cantm_ctrl_s c);
        cantm_pkg::cantm_ctrl_s g;
        g = c;
        if (!c.test_mode_master_enable) begin
            g = '0;
        end
        return g;
    endfunction : gate

    function automatic logic [31:0] ctrl_word(
        input cantm_pkg::cantm_ctrl_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[cantm_pkg::BIT_MASTER] = c.test_mode_master_enable;
        w[cantm_pkg::BIT_AACK]   = c.auto_ack_enable;
        w[cantm_pkg::BIT_FREEZE] = c.error_count_freeze;
        w[cantm_pkg::BIT_RXDIS]  = c.rx_input_disable;
        w[cantm_pkg::BIT_TXDIS]  = c.tx_output_disable;
        w[cantm_pkg::BIT_LOOP]   = c.internal_loop_enable;
        return w;
    endfunction : ctrl_word

    cantm_pkg::cantm_ctrl_s eff;
    assign eff = gate(ctrl_r);

    // answer one cycle after setup: pready rises in the first access cycle
    always_comb begin
        ctrl_nxt    = ctrl_r;
        prdata_nxt  = prdata_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        if (psel && !penable && !pready_r) begin
            pready_nxt  = 1'b1;
            pslverr_nxt = !mapped(paddr);
            prdata_nxt  = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    cantm_pkg::ADDR_CTRL: begin
                        prdata_nxt = ctrl_word(ctrl_r);
                    end
                    cantm_pkg::ADDR_ERRCNT: begin
                        prdata_nxt[cantm_pkg::TEC_LSB +: 9] = tec_w;
                        prdata_nxt[cantm_pkg::REC_LSB +: 8] = rec_w;
                    end
                    cantm_pkg::ADDR_STATUS: begin
                        prdata_nxt = ctrl_word(eff);
                    end
                    default: begin
                        prdata_nxt = 32'h0000_0000;
                    end
                endcase
            end
        end
        // write commits at the edge where pready is seen high
        if (psel && penable && pready_r && pwrite &&
            paddr == cantm_pkg::ADDR_CTRL) begin
            ctrl_nxt.test_mode_master_enable = pwdata[cantm_pkg::BIT_MASTER];
            ctrl_nxt.auto_ack_enable         = pwdata[cantm_pkg::BIT_AACK];
            ctrl_nxt.error_count_freeze      = pwdata[cantm_pkg::BIT_FREEZE];
            ctrl_nxt.rx_input_disable        = pwdata[cantm_pkg::BIT_RXDIS];
            ctrl_nxt.tx_output_disable       = pwdata[cantm_pkg::BIT_TXDIS];
            ctrl_nxt.internal_loop_enable    = pwdata[cantm_pkg::BIT_LOOP];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r    <= {6{cantm_pkg::CTRL_RST}};
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------------
    // transmit and receive path
    // ------------------------------------------------------------------
    logic int_tx;
    logic tx_r, tx_nxt;
    logic rx_r, rx_nxt;

    // own ack forced into the internal tx value, so loopback sees it too
    always_comb begin
        int_tx = core_tx;
        if (eff.auto_ack_enable && core_ack_slot) begin
            int_tx = cantm_pkg::DOMINANT;
        end
    end

    always_comb begin
        tx_nxt = int_tx;
        if (eff.tx_output_disable) begin
            tx_nxt = cantm_pkg::RECESSIVE;
        end
        // master off gives eff all zero, so rx comes from the pin
        if (!eff.rx_input_disable) begin
            rx_nxt = can_rx_pin;
        end else if (eff.internal_loop_enable) begin
            rx_nxt = int_tx;
        end else begin
            rx_nxt = cantm_pkg::RECESSIVE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_r <= cantm_pkg::RECESSIVE;
            rx_r <= cantm_pkg::RECESSIVE;
        end else begin
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
        end
    end

    assign can_tx_pin = tx_r;
    assign core_rx    = rx_r;

    // ------------------------------------------------------------------
    // error counters
    // ------------------------------------------------------------------
    cantm_errcnt #(
        .TW (cantm_pkg::TEC_W),
        .RW (cantm_pkg::REC_W)
    ) u_errcnt (
        .pclk    (pclk),
        .presetn (presetn),
        .freeze  (eff.error_count_freeze),
        .evt     (core_err),
        .tec     (tec_w),
        .rec     (rec_w)
    );

    assign tec = tec_w;
    assign rec = rec_w;

endmodule : cantm_top

// File: include/cantm_pkg.sv
package cantm_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_ERRCNT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // ------------------------------------------------------------------
    // control field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned BIT_MASTER = 15;
    localparam int unsigned BIT_AACK   = 12;
    localparam int unsigned BIT_FREEZE = 11;
    localparam int unsigned BIT_RXDIS  = 10;
    localparam int unsigned BIT_TXDIS  = 9;
    localparam int unsigned BIT_LOOP   = 8;
    localparam logic        CTRL_RST   = 1'b0;

    // errcnt fields
    localparam int unsigned TEC_LSB    = 0;
    localparam int unsigned REC_LSB    = 16;
    localparam int unsigned TEC_W      = 9;
    localparam int unsigned REC_W      = 8;
    localparam logic [8:0]  TEC_MAX    = 9'h1FF;
    localparam logic [7:0]  REC_MAX    = 8'hFF;
    localparam logic [3:0]  STEP_BIG   = 4'h8;
    localparam logic [3:0]  STEP_ONE   = 4'h1;

    // bus levels
    localparam logic        RECESSIVE  = 1'b1;
    localparam logic        DOMINANT   = 1'b0;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic test_mode_master_enable;
        logic auto_ack_enable;
        logic error_count_freeze;
        logic rx_input_disable;
        logic tx_output_disable;
        logic internal_loop_enable;
    } cantm_ctrl_s;

    typedef struct packed {
        logic tec_inc1;
        logic tec_inc8;
        logic tec_dec;
        logic rec_inc1;
        logic rec_inc8;
        logic rec_dec;
    } cantm_err_s;

endpackage : cantm_pkg

// File: tb/cantm_bus_model.sv
`timescale 1ns/1ps
module cantm_bus_model (
    input  wire logic node_tx, // our tx pin
    input  wire logic peer_tx, // other node
    output logic      bus_rx   // bus level
);
    // pull-up bus: recessive unless some node pulls it low
    assign bus_rx = node_tx & peer_tx;
endmodule : cantm_bus_model

// File: tb/cantm_properties.sv
`timescale 1ns/1ps
module cantm_properties (
    input wire logic                  pclk,          // clock
    input wire logic                  presetn,       // reset
    input wire logic                  psel,          // apb
    input wire logic                  penable,       // apb
    input wire logic                  pwrite,        // apb
    input wire logic [7:0]            paddr,         // apb
    input wire logic [31:0]           pwdata,        // apb
    input wire logic [31:0]           prdata,        // apb
    input wire logic                  pready,        // apb
    input wire logic                  pslverr,       // apb
    input wire logic                  core_tx,       // core
    input wire logic                  core_ack_slot, // core
    input wire cantm_pkg::cantm_err_s core_err,      // core
    input wire logic                  can_rx_pin,    // bus
    input wire logic                  can_tx_pin,    // bus
    input wire logic                  core_rx,       // core
    input wire logic [8:0]            tec,           // count
    input wire logic [7:0]            rec            // count
);
    // ------
    // shadow of the control word, rebuilt from bus writes
    // ------
    logic [15:0] ctl_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= 16'h0000;
        end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
            ctl_r <= pwdata[15:0];
        end
    end
    wire m   = ctl_r[15];
    wire ack = m & ctl_r[12];
    wire frz = m & ctl_r[11];
    wire rxd = m & ctl_r[10];
    wire txd = m & ctl_r[9];
    wire lp  = m & ctl_r[8];
    wire itx = core_tx & ~(ack & core_ack_slot);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_rx_pin;
        !rxd |=> core_rx == $past(can_rx_pin);
    endproperty
    a_rx_pin: assert property (p_rx_pin) else $error("rx not from pin");
    property p_rx_rec;
        rxd && !lp |=> core_rx == cantm_pkg::RECESSIVE;
    endproperty
    a_rx_rec: assert property (p_rx_rec) else $error("rx not recessive");
    property p_rx_loop;
        rxd && lp |=> core_rx == $past(itx);
    endproperty
    a_rx_loop: assert property (p_rx_loop) else $error("rx not looped");
    property p_ack;
        ack && core_ack_slot && !txd |=> can_tx_pin == cantm_pkg::DOMINANT;
    endproperty
    a_ack: assert property (p_ack) else $error("no own ack");
    property p_tx;
        !txd |=> can_tx_pin == $past(itx);
    endproperty
    a_tx: assert property (p_tx) else $error("tx pin wrong");
    property p_freeze;
        frz |=> $stable(tec) && $stable(rec);
    endproperty
    a_freeze: assert property (p_freeze) else $error("counter moved");
    property p_tec;
        !frz && core_err.tec_inc8 && !core_err.tec_dec && tec < 9'h1F8
            |=> tec == $past(tec) + 9'h008;
    endproperty
    a_tec: assert property (p_tec) else $error("tec step wrong");
    property p_rec;
        !frz && core_err == 6'h04 && rec != 8'hFF |=> rec == $past(rec) + 8'h01;
    endproperty
    a_rec: assert property (p_rec) else $error("rec step wrong");
    property p_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready not one pulse");
    c_loop: cover property (rxd && lp && !core_tx);
    c_ack: cover property (ack && core_ack_slot);
    c_frz: cover property (frz && core_err.tec_inc8);
endmodule : cantm_properties

bind cantm_top cantm_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_tx(core_tx),
    .core_ack_slot(core_ack_slot), .core_err(core_err),
    .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin), .core_rx(core_rx),
    .tec(tec), .rec(rec)
);

// File: tb/cantm_top_tb_top.sv
`timescale 1ns/1ps
module cantm_top_tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, core_tx = 1'b1, core_ack_slot = 1'b0;
    logic        peer_tx = 1'b1, probe = 1'b0, pready, pslverr;
    logic        can_tx_pin, can_rx_pin, core_rx;
    logic [7:0]  paddr = 8'h00, rec;
    logic [8:0]  tec;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [15:0] ctl = 16'h0;
    logic [32:0] rq[$];
    logic [1:0]  pq[$];
    int          errors = 0, checks_done = 0, cyc = 0, seed = 91;
    int          t_tec = 0, t_rec = 0;
    cantm_pkg::cantm_err_s core_err = '0;
    // 9f00 keeps every bit; 1f00 checks that master off masks them
    localparam logic [15:0] MODES [9] = '{16'h1F00, 16'h8000, 16'h8400,
        16'h8500, 16'h8700, 16'h8100, 16'h9000, 16'h9700, 16'h9200};
    cantm_top uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_tx(core_tx),
        .core_ack_slot(core_ack_slot), .core_err(core_err),
        .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin), .core_rx(core_rx),
        .tec(tec), .rec(rec));
    cantm_bus_model u_bus (
        .node_tx(can_tx_pin), .peer_tx(peer_tx), .bus_rx(can_rx_pin));
    initial begin
        forever #4 pclk = ~pclk;
    end
    task automatic check(input string nm, input logic [32:0] s, e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic print_verdict;
        if (errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    // ------
    // scoreboard side: compares whenever a result appears
    // ------
    always @(posedge pclk) begin
        if (pready && !pwrite && rq.size() > 0)
            check("prdata", {pslverr, prdata}, rq.pop_front());
        if (probe && pq.size() > 0)
            check("pins", {core_rx, can_tx_pin}, pq.pop_front());
        cyc++;
        if (cyc > 8000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        if (!w)
            rq.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wctl(input logic [15:0] v);
        apb(1'b1, cantm_pkg::ADDR_CTRL, {16'h0, v}, 33'h0);
        ctl = v & 16'h9F00;
    endtask : wctl
    task automatic step;
        logic [31:0] r;
        logic        m, it, tp;
        r = $random(seed);
        m = ctl[15];
        it = r[0] & ~(m & ctl[12] & r[1]);
        tp = (m & ctl[9]) | it;
        @(posedge pclk);
        core_tx <= r[0];
        core_ack_slot <= r[1];
        peer_tx <= r[2] | r[3];
        repeat (2) @(posedge pclk);
        pq.push_back({(m & ctl[10]) ? ((m & ctl[8]) ? it : 1'b1)
                      : (tp & (r[2] | r[3])), tp});
        probe <= 1'b1;
        @(posedge pclk);
        probe <= 1'b0;
    endtask : step
    task automatic evt;
        logic [31:0]           r;
        cantm_pkg::cantm_err_s e;
        r = $random(seed);
        e = r[5:0];
        // floor at zero is left out: its order against inc is open
        if (t_tec == 0) e.tec_dec = 1'b0;
        if (t_rec == 0) e.rec_dec = 1'b0;
        @(posedge pclk);
        core_err <= e;
        @(posedge pclk);
        core_err <= '0;
        if (!(ctl[15] & ctl[11])) begin
            t_tec = t_tec + (e.tec_inc8 ? 8 : e.tec_inc1) - e.tec_dec;
            t_rec = t_rec + (e.rec_inc8 ? 8 : e.rec_inc1) - e.rec_dec;
        end
    endtask : evt
    task automatic rd_cnt;
        apb(1'b0, cantm_pkg::ADDR_ERRCNT, 32'h0,
            {9'h000, 8'(t_rec), 7'h00, 9'(t_tec)});
    endtask : rd_cnt
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, cantm_pkg::ADDR_CTRL, 32'h0, 33'h0);
        apb(1'b0, cantm_pkg::ADDR_STATUS, 32'h0, 33'h0);
        apb(1'b1, 8'h0C, 32'hFFFFFFFF, 33'h0);
        apb(1'b0, 8'h0C, 32'h0, 33'h1_0000_0000);
        apb(1'b1, cantm_pkg::ADDR_ERRCNT, 32'hFFFFFFFF, 33'h0);
        rd_cnt();
        wctl(16'hFFFF);
        apb(1'b0, cantm_pkg::ADDR_CTRL, 32'h0, 33'h0_0000_9F00);
        foreach (MODES[i]) begin // via 8700 and 9000
            wctl(MODES[i]);
            apb(1'b0, cantm_pkg::ADDR_STATUS, 32'h0,
                {17'h0, ctl[15] ? ctl : 16'h0});
            repeat (6) step();
        end
        foreach (MODES[i]) begin
            wctl({MODES[i][15], 3'h0, ~MODES[i][11], 11'h0});
            repeat (10) evt();
            rd_cnt();
        end
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        t_tec = 0;
        t_rec = 0;
        ctl = 16'h0;
        rd_cnt();
        apb(1'b0, cantm_pkg::ADDR_CTRL, 32'h0, 33'h0);
        print_verdict();
    end
endmodule : cantm_top_tb_top
